/* bench/kqs_src_model.sv */
// Playback source model closing its end contact after a set play time
`timescale 1ns/1ns
module kqs_src_model #(
	parameter LEN = 20
) (
	input wire i_clk,
	input wire i_rstn,
	input wire [6:0] i_src_sel,
	output reg o_eom
);
	reg [6:0] prev_reg;
	integer cnt;
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			prev_reg <= 7'h0;
			cnt <= 0;
			o_eom <= 1'b0;
		end
		else
		begin
			prev_reg <= i_src_sel;
			if (i_src_sel != prev_reg && i_src_sel != 7'h0)
				cnt <= LEN;
			else if (cnt != 0)
				cnt <= cnt - 1;
			o_eom <= cnt != 0 && cnt <= 4;
		end
	end
endmodule

/* bench/kqs_top_sva.sv */
// Port checker for the event scheduler
`timescale 1ns/1ns
`include "kqs_defs.vh"
module kqs_top_sva #(
	parameter SLOTS = 18,
	parameter SEC_CYCLES = 10
) (
	input wire i_clk,
	input wire i_rstn,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire [31:0] o_rdata,
	input wire i_eom,
	input wire [6:0] o_src_sel,
	input wire [6:0] o_sub_addr,
	input wire o_cue_valid,
	input wire [2:0] o_cue_src,
	input wire [6:0] o_cue_sub,
	input wire o_hold
);
	wire [4:0] k = i_wdata[4:0];
	wire kw = i_wr && i_addr == `KQS_A_KEY;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	chk_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside read cycle");
	chk_src_onehot: assert property ($onehot0(o_src_sel))
		else $error("more than one source selected");
	chk_silence_off: assert property (kw && k == `KQS_K_SILENCE |=> o_src_sel == 7'h0)
		else $error("silence left a source on");
	chk_hold_tgl: assert property (kw && k == `KQS_K_HOLD |=> o_hold != $past(o_hold))
		else $error("hold key did not toggle");
	chk_hold_keep: assert property (o_hold && !kw |=> $stable(o_src_sel))
		else $error("source changed under hold");
	chk_start_air: assert property (kw && k == `KQS_K_START |=> !o_cue_valid ||
		(o_src_sel == (7'h1 << (o_cue_src - 3'h1)) && o_sub_addr == o_cue_sub))
		else $error("start did not launch cued event");
	chk_cue_code: assert property (o_cue_valid |-> o_cue_src != 3'h0 && o_cue_sub <= 7'h63)
		else $error("bad cued event");
	chk_sub_range: assert property (o_sub_addr <= 7'h63)
		else $error("sub-source above 99");
	cover property (kw && k == `KQS_K_START && o_cue_valid);
	cover property (o_hold && $rose(i_eom));
	cover property (kw && k == `KQS_K_LINK);
endmodule
bind kqs_top kqs_top_sva #(.SLOTS(SLOTS), .SEC_CYCLES(SEC_CYCLES)) i_kqs_top_sva (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_eom(i_eom),
	.o_src_sel(o_src_sel), .o_sub_addr(o_sub_addr), .o_cue_valid(o_cue_valid),
	.o_cue_src(o_cue_src), .o_cue_sub(o_cue_sub), .o_hold(o_hold));

/* bench/kqs_top_test.sv */
// Self-checking bench for the event scheduler
`timescale 1ns/1ns
`include "kqs_defs.vh"
module kqs_top_test;
	reg i_clk = 1'b0;
	reg i_rstn = 1'b0;
	reg [7:0] i_addr = 8'h0;
	reg [31:0] i_wdata = 32'h0;
	reg i_wr = 1'b0;
	reg i_rd = 1'b0;
	wire [31:0] o_rdata;
	wire i_eom;
	wire [6:0] o_src_sel;
	wire [6:0] o_sub_addr;
	wire o_cue_valid;
	wire [2:0] o_cue_src;
	wire [6:0] o_cue_sub;
	wire o_hold;
	reg [31:0] v;
	integer err_total = 0;
	integer comparisons = 0;
	integer n;
	kqs_top #(.SEC_CYCLES(10)) i_kqs_top (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_eom(i_eom), .o_src_sel(o_src_sel),
		.o_sub_addr(o_sub_addr), .o_cue_valid(o_cue_valid),
		.o_cue_src(o_cue_src), .o_cue_sub(o_cue_sub), .o_hold(o_hold));
	kqs_src_model #(.LEN(20)) i_kqs_src_model (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_src_sel(o_src_sel), .o_eom(i_eom));
	initial forever #2 i_clk = ~i_clk;
	task chk(input [31:0] s, input [31:0] e);
	begin
		comparisons = comparisons + 1;
		if (s !== e)
		begin
			err_total = err_total + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	end
	endtask
	task wr(input [7:0] a, input [31:0] d);
	begin
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	end
	endtask
	task key(input [4:0] c);
	begin
		wr(`KQS_A_KEY, {27'h0, c});
	end
	endtask
	task rd(input [7:0] a);
	begin
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
		@(posedge i_clk);
	end
	endtask
	task ev(input [4:0] s, input [4:0] t, input [4:0] u);
	begin
		key(s);
		key(t);
		key(u);
		key(`KQS_K_COMMIT);
	end
	endtask
	task slot(input [4:0] i);
	begin
		wr(`KQS_A_SLOT_SEL, {27'h0, i});
		@(posedge i_clk);
		rd(`KQS_A_SLOT_DATA);
	end
	endtask
	task wait_sel(input [6:0] e);
	begin
		n = 0;
		while (o_src_sel !== e && n < 200)
		begin
			@(negedge i_clk);
			n = n + 1;
		end
		@(posedge i_clk);
		chk(o_src_sel, e);
	end
	endtask
	task t_edit;
	begin
		ev(4, 4, 8);
		rd(`KQS_A_STATUS);
		chk(v[12:8], 5'h1);
		slot(0);
		chk(v[10:0], 11'h230);
		key(1);
		key(1);
		key(4);
		key(`KQS_K_INSERT);
		slot(0);
		chk(v[10:0], 11'h08e);
		slot(1);
		chk(v[10:0], 11'h230);
		key(`KQS_K_SKIP);
		slot(0);
		chk(v[10:0], 11'h230);
		chk({o_cue_valid, o_cue_src, o_cue_sub}, 11'h630);
		$display("edit done");
	end
	endtask
	task t_link;
	begin
		ev(2, 0, 0);
		key(9);
		key(`KQS_K_BACK);
		rd(`KQS_A_ENTRY);
		chk(v[13:12], 2'h0);
		repeat (17) key(`KQS_K_BACK);
		rd(`KQS_A_STATUS);
		chk(v[4:0], 5'h2);
		key(`KQS_K_LINK);
		key(`KQS_K_LINK);
		slot(1);
		chk(v[10:0], 11'h100);
		key(`KQS_K_LINK);
		slot(1);
		chk(v[10:0], 11'h500);
		$display("link done");
	end
	endtask
	task t_run;
	begin
		key(`KQS_K_START);
		chk(o_src_sel, 7'h08);
		chk(o_sub_addr, 7'h30);
		rd(`KQS_A_TIMER);
		chk(v[11:0], 12'h0);
		ev(3, 3, 3);
		key(`KQS_K_LINK);
		wait_sel(7'h02);
		wait_sel(7'h04);
		wait_sel(7'h00);
		ev(5, 0, 0);
		key(`KQS_K_START);
		key(`KQS_K_HOLD);
		chk(o_hold, 1'b1);
		repeat (60) @(posedge i_clk);
		chk(o_src_sel, 7'h10);
		key(`KQS_K_HOLD);
		chk(o_hold, 1'b0);
		key(`KQS_K_SILENCE);
		chk(o_src_sel, 7'h00);
		rd(`KQS_A_TIMER);
		chk(v[11:0], 12'h006);
		$display("run done");
	end
	endtask
	task t_stop;
	begin
		ev(0, 0, 0);
		ev(6, 0, 0);
		key(`KQS_K_START);
		chk(o_src_sel, 7'h00);
		rd(`KQS_A_ONAIR);
		chk(v[10:0], 11'h680);
		key(`KQS_K_START);
		chk(o_src_sel, 7'h20);
		ev(1, 0, 0);
		key(`KQS_K_CLEAR);
		rd(`KQS_A_STATUS);
		chk(v[12:8], 5'h0);
		rd(`KQS_A_ONAIR);
		chk(v[10:0], 11'h700);
		for (n = 0; n < 18; n = n + 1)
			ev(1, 0, 0);
		ev(2, 0, 0);
		rd(`KQS_A_STATUS);
		chk(v[13:8], 6'h32);
		slot(17);
		chk(v[10:0], 11'h080);
		$display("stop done");
	end
	endtask
	task stop_test;
	begin
		$display("compares %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	initial
	begin
		#100000;
		err_total = err_total + 1;
		stop_test;
	end
	initial
	begin
		repeat (10) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		t_edit;
		t_link;
		t_run;
		t_stop;
		stop_test;
	end
endmodule

/* include/kqs_defs.vh */
// Constants for the keypad event queue scheduler
`ifndef KQS_DEFS_VH
`define KQS_DEFS_VH
// Register byte offsets
`define KQS_A_KEY 8'h00
`define KQS_A_STATUS 8'h04
`define KQS_A_ONAIR 8'h08
`define KQS_A_TIMER 8'h0c
`define KQS_A_ENTRY 8'h10
`define KQS_A_SLOT_SEL 8'h14
`define KQS_A_SLOT_DATA 8'h18
// Key codes written to the key register, digits are 5'h00 to 5'h09
`define KQS_K_COMMIT 5'h10
`define KQS_K_INSERT 5'h11
`define KQS_K_SILENCE 5'h12
`define KQS_K_CLEAR 5'h13
`define KQS_K_SKIP 5'h14
`define KQS_K_HOLD 5'h15
`define KQS_K_LINK 5'h16
`define KQS_K_START 5'h17
`define KQS_K_BACK 5'h18
// Queue operations
`define KQS_OP_NONE 3'h0
`define KQS_OP_APPEND 3'h1
`define KQS_OP_INSERT 3'h2
`define KQS_OP_DELETE 3'h3
`define KQS_OP_CLEAR 3'h4
`define KQS_OP_LINK 3'h5
// Event word layout: link, source, sub-source
`define KQS_EV_W 11
`define KQS_EV_LINK 10
`define KQS_EV_SRC_HI 9
`define KQS_EV_SRC_LO 7
`define KQS_EV_SUB_HI 6
`define KQS_EV_SUB_LO 0
// Sizes
`define KQS_SLOTS 18
`define KQS_SOURCES 7
`define KQS_MAX_SUB 7'h63
// Timer
`define KQS_SEC_NS 1000000000
`define KQS_CLK_NS 4
`define KQS_MAX_MS 6'h3b
`endif

/* rtl/kqs_slot_mem.v */
// Shifting slot store for the queued events
`timescale 1ns/1ns
`include "kqs_defs.vh"
module kqs_slot_mem #(
	parameter W = `KQS_EV_W,
	parameter DEPTH = `KQS_SLOTS,
	parameter AW = 5
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rstn,
	// Operation
	input wire [2:0] i_op,
	input wire [AW-1:0] i_pos,
	input wire [W-1:0] i_data,
	// Read side
	input wire [AW-1:0] i_rd_addr,
	output reg [W-1:0] o_rd_data,
	output wire [W-1:0] o_head,
	output reg [AW-1:0] o_count
);
	reg [W-1:0] mem [0:DEPTH-1];
	integer i;

	assign o_head = mem[0];

	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem[i] <= {W{1'b0}};
			o_count <= {AW{1'b0}};
			o_rd_data <= {W{1'b0}};
		end
		else
		begin
			o_rd_data <= (i_rd_addr < DEPTH) ? mem[i_rd_addr] : {W{1'b0}};
			case (i_op)
				`KQS_OP_APPEND:
					if (o_count < DEPTH)
					begin
						mem[o_count] <= i_data;
						o_count <= o_count + 1'b1;
					end
				`KQS_OP_INSERT:
					if (o_count < DEPTH && i_pos <= o_count)
					begin
						for (i = 1; i < DEPTH; i = i + 1)
							if (i > i_pos)
								mem[i] <= mem[i-1];
						mem[i_pos] <= i_data;
						o_count <= o_count + 1'b1;
					end
				`KQS_OP_DELETE:
					if (i_pos < o_count)
					begin
						for (i = 0; i < DEPTH - 1; i = i + 1)
							if (i >= i_pos)
								mem[i] <= mem[i+1];
						mem[DEPTH-1] <= {W{1'b0}};
						o_count <= o_count - 1'b1;
					end
				`KQS_OP_CLEAR:
				begin
					for (i = 0; i < DEPTH; i = i + 1)
						mem[i] <= {W{1'b0}};
					o_count <= {AW{1'b0}};
				end
				`KQS_OP_LINK:
					if (i_pos < o_count)
						mem[i_pos][W-1] <= ~mem[i_pos][W-1];
				default:
				begin
				end
			endcase
		end
	end
endmodule

/* rtl/kqs_top.v */
// Keypad driven event queue scheduler with on-air sequencing
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ns
`include "kqs_defs.vh"
// Operation
// - Three typed digits plus commit append an event to the queue tail.
// - Insert places the entered event before the cursor slot, shifting later ones down.
// - Silence drops every source selection at once.
// - Clear empties queue and entry line, on-air event untouched.
// - Skip removes the next queued event and moves the rest up.
// - Hold toggles; while set end of message is ignored, indicator shown.
// - Link toggles the arrow flag on the selected slot; pressing again clears it.
// - Start puts the next event on air; its linked chain then follows.
// - Back key erases an entry digit or steps cursor over the 18 slots.
// - On-air event, all queued slots and entry line are readable.
// - Elapsed mm:ss timer restarts at 00:00 on each start, stops at 59:59.
// - Seven sources, each with sub-sources up to 99.
// - Event is one source digit and two sub-source digits; 00 for single.
// - Code 0-00 halts sequencing until start is pressed again.
// - A linked next event starts by itself when the current one ends.
// - Next event's address is presented ahead for slow sources.
module kqs_top #(
	parameter SLOTS = `KQS_SLOTS,
	parameter SEC_CYCLES = `KQS_SEC_NS / `KQS_CLK_NS
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rstn,
	// Register port
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	// Playback sources
	input wire i_eom,
	output reg [`KQS_SOURCES-1:0] o_src_sel,
	output reg [6:0] o_sub_addr,
	output reg o_cue_valid,
	output reg [2:0] o_cue_src,
	output reg [6:0] o_cue_sub,
	// Indicator
	output reg o_hold
);
	function [`KQS_SOURCES-1:0] src_onehot;
		input [2:0] src;
		begin
			src_onehot = {`KQS_SOURCES{1'b0}};
			if (src != 3'h0)
				src_onehot[src - 3'h1] = 1'b1;
		end
	endfunction

	function [6:0] bcd_to_sub;
		input [3:0] tens;
		input [3:0] units;
		reg [7:0] x;
		begin
			x = {4'h0, tens} * 8'h0a + {4'h0, units};
			bcd_to_sub = x[6:0];
		end
	endfunction

	// Entry line and cursor
	reg [1:0] ndig_reg;
	reg [3:0] dig0_reg;
	reg [3:0] dig1_reg;
	reg [3:0] dig2_reg;
	reg [4:0] cursor_reg;
	reg [4:0] slot_sel_reg;
	// Sequencing state
	reg onair_vld_reg;
	reg [9:0] onair_reg;
	reg running_reg;
	reg eom_s1_reg;
	reg eom_s2_reg;
	reg eom_d_reg;
	reg eom_pend_reg;
	// Timer
	reg [31:0] tick_reg;
	reg [5:0] min_reg;
	reg [5:0] sec_reg;
	// Queue port
	reg [2:0] op;
	reg [4:0] pos;
	reg launch;
	reg end_air;
	reg eom_take;
	wire [`KQS_EV_W-1:0] head;
	wire [`KQS_EV_W-1:0] slot_q;
	wire [4:0] count;

	wire key_stb = i_wr && (i_addr == `KQS_A_KEY);
	wire [4:0] key = i_wdata[4:0];
	wire full = (count == SLOTS[4:0]);
	wire [2:0] head_src = head[`KQS_EV_SRC_HI:`KQS_EV_SRC_LO];
	wire [6:0] head_sub = head[`KQS_EV_SUB_HI:`KQS_EV_SUB_LO];
	wire head_stop = (head_src == 3'h0) && (head_sub == 7'h00);
	wire head_link = head[`KQS_EV_LINK];
	wire [6:0] entry_sub = bcd_to_sub(dig1_reg, dig2_reg);
	wire entry_ok = (ndig_reg == 2'h3) && (dig0_reg[3:0] <= 4'h7) &&
		!(dig0_reg == 4'h0 && entry_sub != 7'h00);
	wire [4:0] sel_pos = (cursor_reg == 5'h00) ? 5'h00 : cursor_reg - 5'h01;
	wire eom_rise = eom_s2_reg && !eom_d_reg;

	kqs_slot_mem #(
		.W(`KQS_EV_W),
		.DEPTH(SLOTS),
		.AW(5)
	) u_mem (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_op(op),
		.i_pos(pos),
		.i_data({1'b0, dig0_reg[2:0], entry_sub}),
		.i_rd_addr(slot_sel_reg),
		.o_rd_data(slot_q),
		.o_head(head),
		.o_count(count)
	);

	// Queue operation and sequencing decisions
	always @*
	begin
		op = `KQS_OP_NONE;
		pos = 5'h00;
		launch = 1'b0;
		end_air = 1'b0;
		eom_take = 1'b0;
		if (key_stb)
		begin
			case (key)
				`KQS_K_COMMIT:
					if (entry_ok && !full)
						op = `KQS_OP_APPEND;
				`KQS_K_INSERT:
					if (entry_ok && !full && sel_pos <= count)
					begin
						op = `KQS_OP_INSERT;
						pos = sel_pos;
					end
				`KQS_K_CLEAR:
					op = `KQS_OP_CLEAR;
				`KQS_K_SKIP:
					if (count != 5'h00)
						op = `KQS_OP_DELETE;
				`KQS_K_LINK:
					if (sel_pos < count)
					begin
						op = `KQS_OP_LINK;
						pos = sel_pos;
					end
				`KQS_K_START:
					if (count != 5'h00)
					begin
						op = `KQS_OP_DELETE;
						launch = !head_stop;
					end
				default:
				begin
				end
			endcase
		end
		else if (eom_pend_reg)
		begin
			eom_take = 1'b1;
			if (!o_hold)
			begin
				end_air = 1'b1;
				if (count != 5'h00 && head_stop)
					op = `KQS_OP_DELETE;
				else if (count != 5'h00 && head_link)
				begin
					op = `KQS_OP_DELETE;
					launch = 1'b1;
					end_air = 1'b0;
				end
			end
		end
	end

	// End of message pin synchroniser and pending flag
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			eom_s1_reg <= 1'b0;
			eom_s2_reg <= 1'b0;
			eom_d_reg <= 1'b0;
			eom_pend_reg <= 1'b0;
		end
		else
		begin
			eom_s1_reg <= i_eom;
			eom_s2_reg <= eom_s1_reg;
			eom_d_reg <= eom_s2_reg;
			if (eom_rise)
				eom_pend_reg <= 1'b1;
			else if (eom_take)
				eom_pend_reg <= 1'b0;
		end
	end

	// Entry line, cursor and hold
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			ndig_reg <= 2'h0;
			dig0_reg <= 4'h0;
			dig1_reg <= 4'h0;
			dig2_reg <= 4'h0;
			cursor_reg <= 5'h00;
			o_hold <= 1'b0;
		end
		else if (key_stb)
		begin
			if (key <= 5'h09 && ndig_reg != 2'h3)
			begin
				case (ndig_reg)
					2'h0: dig0_reg <= key[3:0];
					2'h1: dig1_reg <= key[3:0];
					default: dig2_reg <= key[3:0];
				endcase
				ndig_reg <= ndig_reg + 2'h1;
			end
			case (key)
				`KQS_K_BACK:
					if (cursor_reg == 5'h00 && ndig_reg != 2'h0)
						ndig_reg <= ndig_reg - 2'h1;
					else if (cursor_reg == 5'h00)
						cursor_reg <= SLOTS[4:0];
					else
						cursor_reg <= cursor_reg - 5'h01;
				`KQS_K_COMMIT,
				`KQS_K_INSERT:
					if (op != `KQS_OP_NONE)
						ndig_reg <= 2'h0;
				`KQS_K_CLEAR:
				begin
					ndig_reg <= 2'h0;
					cursor_reg <= 5'h00;
				end
				`KQS_K_HOLD:
					o_hold <= !o_hold;
				default:
				begin
				end
			endcase
		end
	end

	// On-air event, source selection and look-ahead cue
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			onair_vld_reg <= 1'b0;
			onair_reg <= 10'h000;
			running_reg <= 1'b0;
			o_src_sel <= {`KQS_SOURCES{1'b0}};
			o_sub_addr <= 7'h00;
			o_cue_valid <= 1'b0;
			o_cue_src <= 3'h0;
			o_cue_sub <= 7'h00;
		end
		else
		begin
			o_cue_valid <= (count != 5'h00) && !head_stop;
			o_cue_src <= head_src;
			o_cue_sub <= head_sub;
			if (key_stb && key == `KQS_K_SILENCE)
				o_src_sel <= {`KQS_SOURCES{1'b0}};
			else if (launch)
			begin
				onair_vld_reg <= 1'b1;
				onair_reg <= head[9:0];
				running_reg <= 1'b1;
				o_src_sel <= src_onehot(head_src);
				o_sub_addr <= head_sub;
			end
			else if (end_air)
			begin
				o_src_sel <= {`KQS_SOURCES{1'b0}};
				running_reg <= 1'b0;
			end
		end
	end

	// Elapsed timer
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			tick_reg <= 32'h0;
			min_reg <= 6'h00;
			sec_reg <= 6'h00;
		end
		else if (launch)
		begin
			tick_reg <= 32'h0;
			min_reg <= 6'h00;
			sec_reg <= 6'h00;
		end
		else if (tick_reg == SEC_CYCLES - 1)
		begin
			tick_reg <= 32'h0;
			if (sec_reg != `KQS_MAX_MS)
				sec_reg <= sec_reg + 6'h01;
			else if (min_reg != `KQS_MAX_MS)
			begin
				sec_reg <= 6'h00;
				min_reg <= min_reg + 6'h01;
			end
		end
		else
			tick_reg <= tick_reg + 32'h1;
	end

	// Register reads and slot select
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			slot_sel_reg <= 5'h00;
			o_rdata <= 32'h0;
		end
		else
		begin
			if (i_wr && i_addr == `KQS_A_SLOT_SEL)
				slot_sel_reg <= i_wdata[4:0];
			o_rdata <= 32'h0;
			if (i_rd)
			begin
				case (i_addr)
					`KQS_A_STATUS:
						o_rdata <= {16'h0, o_hold, running_reg, full,
							count, 3'h0, cursor_reg};
					`KQS_A_ONAIR:
						o_rdata <= {21'h0, onair_vld_reg, onair_reg};
					`KQS_A_TIMER:
						o_rdata <= {20'h0, min_reg, sec_reg};
					`KQS_A_ENTRY:
						o_rdata <= {18'h0, ndig_reg, dig0_reg, dig1_reg,
							dig2_reg};
					`KQS_A_SLOT_SEL:
						o_rdata <= {27'h0, slot_sel_reg};
					`KQS_A_SLOT_DATA:
						o_rdata <= {21'h0, slot_q};
					default:
						o_rdata <= 32'h0;
				endcase
			end
		end
	end
endmodule
